//--- logic/adc_clock_pll_cfg.sv
// sample clock front end, duty correction and pll band selection
// What this block does
// - one clock feeds all eight matched channel strobes
// - select bit picks single-ended or differential mode
// - pll sits in one of four bands
// - threshold crossings move band, with hysteresis
// - three thresholds lie between 10 and 45 MHz
// - band may change at every measurement window end until pinned
// - at 45 MHz or more band moves to the top band and stays there
`timescale 1ns/1ns
module adc_clock_pll_cfg
  import pll_cfg_pkg::*;
(
  input  wire logic                    MCLK_IN,
  input  wire logic                    RST_B_IN,
  input  wire logic                    CE_IN,
  input  wire logic                    SAMPLE_CLK_P_IN,
  input  wire logic                    SAMPLE_CLK_N_IN,
  input  wire logic                    DIFFERENTIAL_CLOCK_SELECT_IN,
  input  wire logic                    DUTY_CORRECTION_ENABLE_IN,
  input  wire logic                    REG_WR_IN,
  input  wire logic [7:0]              REG_ADDR_IN,
  input  wire logic [15:0]             REG_DATA_IN,
  output logic                         FRAME_SAMPLE_CLOCK_OUT,
  output logic [NUM_CHANNELS-1:0]      CHANNEL_SAMPLE_OUT,
  output logic [3:0]                   PLL_BAND_OUT,
  output logic [1:0]                   PLL_STATE_OUT,
  output logic                         PLL_AUTO_OUT,
  output logic [CNT_W-1:0]             FREQ_MHZ_OUT,
  output logic                         CLOCK_MODE_DIFF_OUT,
  output logic                         DUTY_CORRECTION_ACTIVE_OUT
);

  freq_det_if fd ();

  logic                    sel_clk;
  logic                    sel_d1_reg;
  logic                    edge_pulse;
  logic                    diff_reg;
  logic                    duty_corr_reg;
  logic [CNT_W-1:0]        period_cnt_reg;
  logic [CNT_W-1:0]        period_reg;
  logic [CNT_W-1:0]        high_left_reg;
  logic [CNT_W-1:0]        half_period;
  logic                    frame_reg;
  logic [NUM_CHANNELS-1:0] chan_reg;
  pll_band_e               band_reg;
  pll_band_e               band_next;
  logic                    unlocked_reg;
  logic                    pinned_reg;
  logic                    unlock_wr;
  logic                    pin_wr;
  logic                    pin_low;
  logic                    pin_high;
  logic [1:0]              idx_up;
  logic [1:0]              idx_dn;
  logic [1:0]              idx_cur;
  logic [1:0]              idx_new;

  function automatic pll_band_e band_of(input logic [1:0] idx);
    pll_band_e b;
    b = PLL_BAND0;
    unique case (idx)
      2'h0: b = PLL_BAND0;
      2'h1: b = PLL_BAND1;
      2'h2: b = PLL_BAND2;
      2'h3: b = PLL_BAND3;
    endcase
    return b;
  endfunction

  // differential mode compares the pair, single-ended uses the p leg
  assign sel_clk    = diff_reg ? (SAMPLE_CLK_P_IN & ~SAMPLE_CLK_N_IN) : SAMPLE_CLK_P_IN;
  assign edge_pulse = sel_clk & ~sel_d1_reg;

  assign fd.ce        = CE_IN;
  assign fd.edge_seen = edge_pulse;

  freq_detector u_det (
    .MCLK_IN  (MCLK_IN),
    .RST_B_IN (RST_B_IN),
    .fd       (fd)
  );

  always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      diff_reg      <= 1'b0;
      duty_corr_reg <= 1'b0;
    end else if (CE_IN) begin
      diff_reg      <= DIFFERENTIAL_CLOCK_SELECT_IN;
      duty_corr_reg <= DUTY_CORRECTION_ENABLE_IN;
    end
  end

  always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      sel_d1_reg <= 1'b0;
    end else if (CE_IN) begin
      sel_d1_reg <= sel_clk;
    end
  end

  // period measurement for duty correction
  always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      period_cnt_reg <= 8'h01;
      period_reg     <= 8'h02;
    end else if (CE_IN) begin
      if (edge_pulse) begin
        period_cnt_reg <= 8'h01;
        period_reg     <= period_cnt_reg;
      end else if (period_cnt_reg != CNT_MAX) begin
        period_cnt_reg <= period_cnt_reg + 8'h01;
      end
    end
  end

  assign half_period = (period_reg[CNT_W-1:1] == 7'h00) ? 8'h01 : {1'b0, period_reg[CNT_W-1:1]};

  always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      high_left_reg <= 8'h00;
    end else if (CE_IN) begin
      if (edge_pulse) begin
        high_left_reg <= half_period;
      end else if (high_left_reg != 8'h00) begin
        high_left_reg <= high_left_reg - 8'h01;
      end
    end
  end

  // frame clock: regenerated at half period when correcting
  always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      frame_reg <= 1'b0;
    end else if (CE_IN) begin
      frame_reg <= duty_corr_reg ? (edge_pulse || high_left_reg > 8'h01) : sel_clk;
    end
  end

  // matched strobe tree: identical single stage per channel
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
      always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
          chan_reg[ch] <= 1'b0;
        end else if (CE_IN) begin
          chan_reg[ch] <= edge_pulse;
        end
      end
    end
  endgenerate

  // pinning writes
  assign unlock_wr = REG_WR_IN && REG_ADDR_IN == REG_UNLOCK_ADDR && REG_DATA_IN == UNLOCK_KEY;
  assign pin_low   = REG_DATA_IN == OVR_LOW_RANGE;
  assign pin_high  = REG_DATA_IN == OVR_HIGH_RANGE;
  assign pin_wr    = REG_WR_IN && REG_ADDR_IN == REG_OVERRIDE_ADDR && unlocked_reg && (pin_low || pin_high);

  always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      unlocked_reg <= 1'b0;
      pinned_reg   <= 1'b0;
    end else if (CE_IN) begin
      if (unlock_wr) begin
        unlocked_reg <= 1'b1;
      end
      if (pin_wr) begin
        pinned_reg <= 1'b1;
      end
    end
  end

  // band window from thresholds: up needs thr+hyst, staying needs thr-hyst
  always_comb begin
    idx_up  = 2'(fd.count >= THR1_MHZ + HYST_MHZ) + 2'(fd.count >= THR2_MHZ + HYST_MHZ)
            + 2'(fd.count >= THR3_MHZ + HYST_MHZ);
    idx_dn  = 2'(fd.count >= THR1_MHZ - HYST_MHZ) + 2'(fd.count >= THR2_MHZ - HYST_MHZ)
            + 2'(fd.count >= THR3_MHZ - HYST_MHZ);
    idx_cur = band_index(band_reg);
    idx_new = idx_cur;
    if (idx_cur < idx_up) begin
      idx_new = idx_up;
    end else if (idx_cur > idx_dn) begin
      idx_new = idx_dn;
    end
    band_next = band_reg;
    if (pin_wr) begin
      band_next = pin_low ? BAND_OVR_LOW : BAND_OVR_HIGH;
    end else if (!pinned_reg && fd.done) begin
      band_next = band_of(idx_new);
    end
  end

  always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      band_reg <= BAND_RESET;
    end else if (CE_IN) begin
      band_reg <= band_next;
    end
  end

  assign FRAME_SAMPLE_CLOCK_OUT = frame_reg;
  assign CHANNEL_SAMPLE_OUT     = chan_reg;
  assign PLL_BAND_OUT           = band_reg;
  assign PLL_STATE_OUT          = band_index(band_reg);
  assign PLL_AUTO_OUT           = ~pinned_reg;
  assign FREQ_MHZ_OUT           = fd.count;
  assign CLOCK_MODE_DIFF_OUT    = diff_reg;
  assign DUTY_CORRECTION_ACTIVE_OUT = duty_corr_reg;

  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!RST_B_IN);

  sequence s_unlock;
    CE_IN && unlock_wr;
  endsequence

  sequence s_pin_low;
    CE_IN && REG_WR_IN && REG_ADDR_IN == REG_OVERRIDE_ADDR && REG_DATA_IN == OVR_LOW_RANGE;
  endsequence

  a_channels_matched: assert property (CE_IN && edge_pulse |=> chan_reg == '1 && $onehot0(~chan_reg)
  ) else $error("channel strobes not matched on edge");

  // reset must be released at the sampling edge, else the reset edge's attempt sees a stale bit
  a_mode_follows_bit: assert property (RST_B_IN && CE_IN |=> diff_reg == $past(DIFFERENTIAL_CLOCK_SELECT_IN))
    else $error("clock mode does not follow select bit");

  a_frame_plain: assert property (RST_B_IN && CE_IN && !duty_corr_reg |=> frame_reg == $past(sel_clk))
    else $error("frame clock does not follow input");

  a_band_onehot: assert property ($onehot(band_reg))
    else $error("pll band not one-hot");

  a_hyst_hold: assert property (CE_IN && !pinned_reg && !pin_wr && fd.done && band_reg == PLL_BAND1
    && fd.count >= THR1_MHZ - HYST_MHZ && fd.count < THR2_MHZ + HYST_MHZ |=> band_reg == PLL_BAND1)
    else $error("band moved inside hysteresis window");

  a_low_freq_band: assert property (CE_IN && !pinned_reg && !pin_wr && fd.done && fd.count < RANGE_LOW
    |=> band_reg == PLL_BAND0)
    else $error("band not lowest below range");

  a_change_at_window: assert property (CE_IN && !fd.done && !pin_wr |=> $stable(band_reg))
    else $error("band changed outside a measurement end");

  a_top_band_stable: assert property (CE_IN && !pinned_reg && !pin_wr && fd.done && fd.count >= RANGE_TOP
    |=> band_reg == PLL_BAND3 ##1 (!fd.done || fd.count < RANGE_TOP || band_reg == PLL_BAND3))
    else $error("band not top at high rate");

  a_pin_sequence: assert property (s_unlock ##1 s_pin_low |=> pinned_reg && band_reg == PLL_BAND1)
    else $error("pinning sequence did not pin band");

  a_pinned_hold: assert property (pinned_reg && !pin_wr |=> $stable(band_reg) && pinned_reg)
    else $error("pinned band changed");

  a_pin_needs_unlock: assert property (!unlocked_reg && !pinned_reg |=> !pinned_reg)
    else $error("band pinned without unlock");

endmodule

//--- logic/freq_det_if.sv
// carrier between clock front end and frequency detector
`timescale 1ns/1ns
interface freq_det_if;
  import pll_cfg_pkg::*;
  logic             ce;
  logic             edge_seen;
  logic             done;
  logic [CNT_W-1:0] count;
  modport det  (input ce, input edge_seen, output done, output count);
  modport cons (output ce, output edge_seen, input done, input count);
endinterface

//--- logic/freq_detector.sv
// gated edge counter measuring sampling frequency in MHz
`timescale 1ns/1ns
module freq_detector
  import pll_cfg_pkg::*;
(
  input  wire logic MCLK_IN,
  input  wire logic RST_B_IN,
  freq_det_if.det   fd
);

  logic [CNT_W-1:0] gate_reg;
  logic [CNT_W-1:0] edge_cnt_reg;
  logic [CNT_W-1:0] count_reg;
  logic             done_reg;
  logic             gate_end;

  assign gate_end = (gate_reg == GATE_LAST);
  assign fd.done  = done_reg;
  assign fd.count = count_reg;

  always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      gate_reg <= 8'h00;
    end else if (fd.ce) begin
      gate_reg <= gate_end ? 8'h00 : gate_reg + 8'h01;
    end
  end

  // saturating edge count, restarted every window
  always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      edge_cnt_reg <= 8'h00;
    end else if (fd.ce) begin
      if (gate_end) begin
        edge_cnt_reg <= 8'h00;
      end else if (fd.edge_seen && edge_cnt_reg != CNT_MAX) begin
        edge_cnt_reg <= edge_cnt_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      count_reg <= 8'h00;
      done_reg  <= 1'b0;
    end else if (fd.ce) begin
      done_reg <= gate_end;
      if (gate_end) begin
        count_reg <= (fd.edge_seen && edge_cnt_reg != CNT_MAX) ? edge_cnt_reg + 8'h01 : edge_cnt_reg;
      end
    end
  end

endmodule

//--- logic/pll_cfg_pkg.sv
// constants and types shared by the sample-clock and pll configuration logic
package pll_cfg_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int GATE_TIME_NS  = 1000;
  localparam int GATE_CYCLES   = GATE_TIME_NS / CLK_PERIOD_NS;
  localparam int NUM_CHANNELS  = 8;
  localparam int CNT_W         = 8;

  localparam logic [CNT_W-1:0] GATE_LAST = CNT_W'(GATE_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_MAX   = 8'hFF;

  // register map of the serial register port
  localparam logic [7:0]  REG_UNLOCK_ADDR   = 8'h01;
  localparam logic [7:0]  REG_OVERRIDE_ADDR = 8'hE3;
  localparam logic [15:0] UNLOCK_KEY        = 16'h0010;
  localparam logic [15:0] OVR_LOW_RANGE     = 16'h0060;
  localparam logic [15:0] OVR_HIGH_RANGE    = 16'h00A0;

  // band thresholds in MHz of sampling clock, edges per gate window
  localparam logic [CNT_W-1:0] THR1_MHZ  = 8'h12;
  localparam logic [CNT_W-1:0] THR2_MHZ  = 8'h1C;
  localparam logic [CNT_W-1:0] THR3_MHZ  = 8'h26;
  localparam logic [CNT_W-1:0] HYST_MHZ  = 8'h02;
  localparam logic [CNT_W-1:0] RANGE_LOW = 8'h0A;
  localparam logic [CNT_W-1:0] RANGE_TOP = 8'h2D;

  typedef enum logic [3:0] {
    PLL_BAND0 = 4'h1,
    PLL_BAND1 = 4'h2,
    PLL_BAND2 = 4'h4,
    PLL_BAND3 = 4'h8
  } pll_band_e;

  localparam pll_band_e BAND_RESET    = PLL_BAND0;
  localparam pll_band_e BAND_OVR_LOW  = PLL_BAND1;
  localparam pll_band_e BAND_OVR_HIGH = PLL_BAND2;

  function automatic logic [1:0] band_index(input pll_band_e b);
    logic [1:0] idx;
    idx = 2'h0;
    unique case (b)
      PLL_BAND0: idx = 2'h0;
      PLL_BAND1: idx = 2'h1;
      PLL_BAND2: idx = 2'h2;
      PLL_BAND3: idx = 2'h3;
      default:   idx = 2'h0;
    endcase
    return idx;
  endfunction

endpackage

//--- tb/samp_clk_src.sv
// sampling clock source: set edge count per 100-cycle frame
`timescale 1ns/1ns
module samp_clk_src (
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       diff_in,
  input  wire logic       n_high_in,
  input  wire logic [7:0] rate_in,
  output logic            p_out,
  output logic            n_out,
  output logic [7:0]      phase_out
);
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      phase_out <= 8'h00;
    end else begin
      phase_out <= (phase_out == 8'h63) ? 8'h00 : phase_out + 8'h01;
    end
  end
  // pulses on odd phases from 3, clear of frame edges
  assign p_out = phase_out[0] && (phase_out >= 8'h03) && (phase_out < 8'h03 + {rate_in[6:0], 1'b0});
  // n leg at 0 when single-ended, inverse when differential; n_high_in is a stuck leg
  assign n_out = n_high_in | (diff_in & ~p_out);
endmodule

//--- tb/tb_top.sv
// self-checking bench for the sample-clock and pll band logic
`timescale 1ns/1ns
module tb_top;
  import pll_cfg_pkg::*;
  typedef struct {logic diff; logic nh; logic [7:0] rate; logic [7:0] f; logic [3:0] band;} row_s;
  logic                    clk = 1'b0;
  logic                    rst_b = 1'b0;
  logic                    ce = 1'b1;
  logic                    diff = 1'b0;
  logic                    duty_en = 1'b0;
  logic                    wr = 1'b0;
  logic [7:0]              addr = 8'h00;
  logic [15:0]             data = 16'h0000;
  logic                    n_high = 1'b0;
  logic [7:0]              rate = 8'h00;
  logic                    p;
  logic                    n;
  logic [7:0]              phase;
  logic                    frame;
  logic [NUM_CHANNELS-1:0] strobe;
  logic [3:0]              band;
  logic [1:0]              state;
  logic                    auto;
  logic [CNT_W-1:0]        freq;
  logic                    mode_diff;
  logic                    duty_act;
  logic                    prev;
  logic                    prev2;
  int                      cnt;
  int                      err_total = 0;
  int                      n_tests = 0;
  row_s rows [12] = '{
    '{1'h0, 1'h0, 8'h14, 8'h14, 4'h2}, '{1'h0, 1'h0, 8'h13, 8'h13, 4'h2}, '{1'h0, 1'h0, 8'h10, 8'h10, 4'h2},
    '{1'h0, 1'h0, 8'h0F, 8'h0F, 4'h1}, '{1'h0, 1'h0, 8'h13, 8'h13, 4'h1}, '{1'h0, 1'h0, 8'h2D, 8'h2D, 4'h8},
    '{1'h0, 1'h0, 8'h25, 8'h25, 4'h8}, '{1'h0, 1'h0, 8'h23, 8'h23, 4'h4}, '{1'h0, 1'h0, 8'h0A, 8'h0A, 4'h1},
    '{1'h1, 1'h0, 8'h1E, 8'h1E, 4'h4}, '{1'h1, 1'h1, 8'h1E, 8'h00, 4'h1}, '{1'h0, 1'h1, 8'h1E, 8'h1E, 4'h4}};

  always #5 clk = ~clk;

  samp_clk_src i_src (.clk_in(clk), .rst_b_in(rst_b), .diff_in(diff), .n_high_in(n_high),
    .rate_in(rate), .p_out(p), .n_out(n), .phase_out(phase));

  adc_clock_pll_cfg i_dut (.MCLK_IN(clk), .RST_B_IN(rst_b), .CE_IN(ce), .SAMPLE_CLK_P_IN(p),
    .SAMPLE_CLK_N_IN(n), .DIFFERENTIAL_CLOCK_SELECT_IN(diff), .DUTY_CORRECTION_ENABLE_IN(duty_en),
    .REG_WR_IN(wr), .REG_ADDR_IN(addr), .REG_DATA_IN(data), .FRAME_SAMPLE_CLOCK_OUT(frame),
    .CHANNEL_SAMPLE_OUT(strobe), .PLL_BAND_OUT(band), .PLL_STATE_OUT(state), .PLL_AUTO_OUT(auto),
    .FREQ_MHZ_OUT(freq), .CLOCK_MODE_DIFF_OUT(mode_diff), .DUTY_CORRECTION_ACTIVE_OUT(duty_act));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // returns just after the edge that starts the last cycle of a frame
  task automatic sync;
    repeat (101) begin
      @(posedge clk);
      #1;
      if (phase === 8'h63) return;
    end
    err_total++;
    give_verdict();
  endtask

  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    data <= d;
  endtask

  task automatic idle;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      sync();
      diff <= rows[i].diff;
      n_high <= rows[i].nh;
      rate <= rows[i].rate;
      sync();
      cnt = 0;
      prev = 1'b0;
      prev2 = 1'b0;
      repeat (100) begin
        @(posedge clk);
        #1;
        chk("strobe_form", strobe, {8{prev & ~prev2}});
        chk("frame_clk", frame, prev);
        if (strobe === 8'hFF) cnt++;
        prev2 = prev;
        prev = diff ? (p & ~n) : p;
      end
      chk("strobes", 16'(cnt), rows[i].f);
      chk("freq", freq, rows[i].f);
      chk("band", band, rows[i].band);
      chk("auto", auto, 1'b1);
    end
    wreg(8'hE3, 16'h0060);
    idle();
    chk("auto_nolock", auto, 1'b1);
    chk("band_nolock", band, 4'h4);
    wreg(8'h01, 16'h0011);
    wreg(8'hE3, 16'h0060);
    idle();
    chk("auto_badkey", auto, 1'b1);
    wreg(8'h01, 16'h0010);
    wreg(8'hE3, 16'h0060);
    idle();
    chk("band_pin_lo", band, 4'h2);
    chk("state_pin_lo", state, 2'h1);
    chk("auto_pinned", auto, 1'b0);
    rate <= 8'h2D;
    repeat (3) sync();
    chk("band_held", band, 4'h2);
    chk("freq_held", freq, 8'h2D);
    wreg(8'hE3, 16'h00A0);
    idle();
    chk("band_pin_hi", band, 4'h4);
    chk("state_pin_hi", state, 2'h2);
    wreg(8'hE3, 16'h0061);
    wreg(8'h02, 16'h0060);
    idle();
    chk("band_bad_wr", band, 4'h4);
    diff <= 1'b1;
    duty_en <= 1'b1;
    @(posedge clk);
    #1;
    chk("mode_diff", mode_diff, 1'b1);
    chk("duty_on", duty_act, 1'b1);
    // enable low: a window end would otherwise latch a new count
    ce <= 1'b0;
    repeat (150) @(posedge clk);
    #1;
    chk("ce_hold_freq", freq, 8'h2D);
    chk("ce_hold_band", band, 4'h4);
    ce <= 1'b1;
    repeat (200) @(posedge clk);
    #1;
    chk("ce_resume_freq", freq, 8'h00);
    @(posedge clk);
    rst_b <= 1'b0;
    #1;
    chk("rst_band", band, 4'h1);
    chk("rst_state", state, 2'h0);
    chk("rst_auto", auto, 1'b1);
    chk("rst_freq", freq, 8'h00);
    chk("rst_strobe", strobe, 8'h00);
    chk("rst_mode", mode_diff, 1'b0);
    chk("rst_duty", duty_act, 1'b0);
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("mode_after", mode_diff, 1'b1);
    give_verdict();
  end
endmodule
